// *** bench/cap_pin_load.sv ***
/*
  load model on the module pins: counts level changes on one pin.
  assumes: pins are plain push-pull levels sampled on the system clock.
*/
`timescale 1ns/10ps
module cap_pin_load #(
  parameter int PIN = 2                  // pin that is watched
) (
  input  wire logic       clk_in,        // system clock
  input  wire logic       sys_rst_in,    // synchronous reset, high
  input  wire logic [4:0] pins_in,       // module pin levels
  output logic      [7:0] edges_out      // level changes seen
);
  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  logic last_q;                          // pin level one cycle ago

  // count both edges, a toggle output moves once per match
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      last_q    <= 1'b0;
      edges_out <= 8'h00;
    end else begin
      last_q <= pins_in[PIN];
      if (pins_in[PIN] !== last_q) begin
        edges_out <= edges_out + 8'h01;
      end
    end
  end
endmodule

// *** bench/tb.sv ***
/*
  self-checking bench for the compare block: apb tasks, one task per case.
  assumes: cap_top with zero-wait apb, pin load model on the pins.
*/
`timescale 1ns/10ps
`include "cap_regs.svh"
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed nets
  // ----------------------------------------------------------------
  localparam logic [7:0] MD_IRQ = 8'h01;   // irq enable
  localparam logic [7:0] MD_PWM = 8'h02;   // pwm mode
  localparam logic [7:0] MD_FLP = 8'h04;   // toggle enable
  localparam logic [7:0] MD_FLG = 8'h08;   // match flag enable
  localparam logic [7:0] MD_CMP = 8'h40;   // compare enable
  localparam logic [7:0] RUN    = 8'h40;   // counter run
  logic        clk_in;                     // system clock
  logic        sys_rst_in;                 // reset, high
  logic        psel, penable, pwrite;      // apb control
  logic [11:0] paddr;                      // apb address
  logic [31:0] pwdata;                     // apb write data
  logic [31:0] prdata;                     // apb read data
  logic        pready, pslverr;            // apb answer
  logic [4:0]  pins;                       // module pins
  logic        irq, wdog;                  // irq and reset request
  logic [7:0]  edges;                      // edges from load model
  logic [31:0] rd;                         // last read data
  logic        err_seen;                   // last slave error
  int          fail_count, samples_checked, cycles, wdog_pulses;

  cap_top u_cap_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .module_io_pin_out(pins), .irq_out(irq), .wdog_reset_out(wdog));
  cap_pin_load u_cap_pin_load (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .pins_in(pins), .edges_out(edges));

  // ----------------------------------------------------------------
  // clock, timeout and reset request counter
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // each cycle of a high request is counted, so a pulse must count one
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (wdog === 1'b1) wdog_pulses <= wdog_pulses + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a hung transfer
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(nm, rd, {24'h00_0000, exp});
  endtask
  // low byte first, then high byte, never zero
  task automatic set_cmp(input logic [9:0] n, input logic [15:0] v);
    wr(`CAP_IDX_CMP_LO0 + n, v[7:0]);
    wr(`CAP_IDX_CMP_HI0 + n, v[15:8]);
  endtask
  task automatic run_from(input logic [15:0] v);
    wr(`CAP_IDX_CTRL, 8'h00);
    wr(`CAP_IDX_CNT_LO, v[7:0]);
    wr(`CAP_IDX_CNT_HI, v[15:8]);
    wr(`CAP_IDX_CTRL, RUN);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int n = 0; n < 5; n++) begin
      rdchk("mode reset", `CAP_IDX_MODE0 + 10'(n), 8'h00);
      rdchk("cmp high reset", `CAP_IDX_CMP_HI0 + 10'(n), 8'h00);
    end
    rdchk("ctrl reset", `CAP_IDX_CTRL, 8'h00);
    apb(1'b0, 10'h000, 8'h00);
    check("unmapped error", {31'h0, err_seen}, 32'h0000_0001);
    check("pins reset", {27'h0, pins}, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_enable_side();
    wr(`CAP_IDX_CMP_HI0, 8'h12);
    rdchk("mode after high", `CAP_IDX_MODE0, MD_CMP);
    wr(`CAP_IDX_CMP_LO0, 8'h34);
    rdchk("mode after low", `CAP_IDX_MODE0, 8'h00);
    rdchk("cmp low back", `CAP_IDX_CMP_LO0, 8'h34);
    $display("test enable side effects done");
  endtask
  // match at 0x0105 only, not at the earlier low byte 0x05
  task automatic t_timer();
    logic [15:0] cnt;
    set_cmp(10'd1, 16'h0105);
    wr(`CAP_IDX_MODE0 + 10'd1, MD_CMP | MD_FLG | MD_IRQ);
    run_from(16'h0000);
    for (int n = 0; n < 200 && rd[1] !== 1'b1; n++) apb(1'b0, `CAP_IDX_CTRL, 8'h00);
    check("flag set by match", {31'h0, rd[1]}, 32'h0000_0001);
    wr(`CAP_IDX_CTRL, 8'h02);
    rdchk("flag sticky", `CAP_IDX_CTRL, 8'h02);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, `CAP_IDX_CNT_LO, 8'h00);
    cnt[7:0] = rd[7:0];
    apb(1'b0, `CAP_IDX_CNT_HI, 8'h00);
    cnt[15:8] = rd[7:0];
    check("match point", {31'h0, cnt >= 16'h0106 && cnt <= 16'h0110}, 32'h1);
    wr(`CAP_IDX_MODE0 + 10'd1, MD_CMP | MD_FLG);
    @(negedge clk_in);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(`CAP_IDX_CTRL, 8'h00);
    rdchk("flag cleared", `CAP_IDX_CTRL, 8'h00);
    $display("test timer done");
  endtask
  task automatic t_toggle();
    int n;
    set_cmp(10'd2, 16'h0020);
    wr(`CAP_IDX_MODE0 + 10'd2, MD_CMP | MD_FLG | MD_FLP);
    run_from(16'h0000);
    for (n = 0; n < 100 && pins[2] !== 1'b1; n++) @(negedge clk_in);
    check("pin first match", {31'h0, pins[2]}, 32'h0000_0001);
    set_cmp(10'd2, 16'h0070);
    for (n = 0; n < 200 && pins[2] !== 1'b0; n++) @(negedge clk_in);
    @(negedge clk_in);   // load model counts one edge after the pin moves
    check("pin edges", {24'h0, edges}, 32'h0000_0002);
    wr(`CAP_IDX_MODE0 + 10'd2, 8'h00);
    $display("test toggle done");
  endtask
  task automatic count_high(input int p, input int exp);
    int h;
    h = 0;
    repeat (256) begin
      @(negedge clk_in);
      if (pins[p] === 1'b1) h = h + 1;
    end
    check("pwm high cycles", h, exp);
  endtask
  task automatic t_pwm();
    wr(`CAP_IDX_CMP_HI0 + 10'd3, 8'h80);
    wr(`CAP_IDX_MODE0 + 10'd3, MD_CMP | MD_PWM);
    wr(`CAP_IDX_CMP_HI0, 8'hC0);
    wr(`CAP_IDX_MODE0, MD_CMP | MD_PWM);
    wr(`CAP_IDX_CMP_HI0 + 10'd4, 8'h40);
    wr(`CAP_IDX_MODE0 + 10'd4, MD_PWM);
    run_from(16'h0000);
    repeat (300) @(negedge clk_in);
    count_high(3, 128);
    count_high(0, 64);
    count_high(4, 0);
    wr(`CAP_IDX_CMP_HI0 + 10'd3, 8'h40);
    repeat (300) @(negedge clk_in);
    count_high(3, 192);
    wr(`CAP_IDX_CTRL, 8'h00);
    for (int n = 0; n < 5; n++) wr(`CAP_IDX_MODE0 + 10'(n), 8'h00);
    $display("test pwm done");
  endtask
  task automatic t_watchdog();
    int p0;
    set_cmp(10'd4, 16'h0030);
    wr(`CAP_IDX_MODE0 + 10'd4, MD_CMP | MD_FLG);
    wr(`CAP_IDX_WDOG, 8'h40);
    p0 = wdog_pulses;
    run_from(16'h0000);
    repeat (80) @(negedge clk_in);
    check("wdog one pulse", wdog_pulses - p0, 1);
    wr(`CAP_IDX_WDOG, 8'h00);
    run_from(16'h0000);
    repeat (80) @(negedge clk_in);
    check("wdog disabled", wdog_pulses - p0, 1);
    wr(`CAP_IDX_WDOG, 8'h40);
    run_from(16'h0000);
    repeat (80) @(negedge clk_in);
    check("wdog rearmed", wdog_pulses - p0, 2);
    // feeding: compare moved ahead of the counter, so no reset
    run_from(16'h0000);
    repeat (3) begin
      repeat (20) @(negedge clk_in);
      apb(1'b0, `CAP_IDX_CNT_LO, 8'h00);
      set_cmp(10'd4, {8'h00, rd[7:0] + 8'h30});
    end
    check("wdog fed", wdog_pulses - p0, 2);
    wr(`CAP_IDX_MODE0 + 10'd4, 8'h00);
    set_cmp(10'd1, 16'h0030);
    run_from(16'h0000);
    repeat (80) @(negedge clk_in);
    check("wdog other module", wdog_pulses - p0, 2);
    wr(`CAP_IDX_CTRL, 8'h00);
    $display("test watchdog done");
  endtask

  // ----------------------------------------------------------------
  // closing and main sequence
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_count, samples_checked, cycles, wdog_pulses} = '0;
    sys_rst_in = 1'b1;
    rd         = 32'h0000_0000;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_enable_side();
    t_timer();
    t_toggle();
    t_pwm();
    t_watchdog();
    complete_run();
  end
endmodule

// *** logic/cap_cmp_unit.sv ***
/*
  one compare module: 16-bit match, toggling output and 8-bit pwm with
  buffered duty.
  assumes: counter and compare values come from the owner's registers,
  tick marks the cycle in which the shared counter steps.
*/
`timescale 1ns/10ps
`include "cap_regs.svh"
module cap_cmp_unit
  import cap_pkg::*;
(
  input  wire logic        clk_in,        // system clock
  input  wire logic        sys_rst_in,    // synchronous reset, high
  input  wire logic        tick_in,       // counter steps this cycle
  input  wire logic [15:0] count_in,      // shared counter value
  input  wire logic [15:0] compare_in,    // {high, low} compare bytes
  input  wire logic        compare_enable_in,       // compare_enable
  input  wire logic        mat_in,        // match_flag_enable
  input  wire logic        tog_in,        // toggle_enable
  input  wire logic        pwm_in,        // pwm mode bit
  output logic             match_out,     // one-cycle match pulse
  output logic             pin_out        // module_io_pin level
);

  // ----------------------------------------------------------------------
  // mode decode and match
  // ----------------------------------------------------------------------
  cap_func_t fn;           // current function
  logic      pin_q;        // registered pin level
  logic      pin_d;
  cap_byte_t duty_q;       // active duty byte
  cap_byte_t duty_d;

  always_comb begin
    if (compare_enable_in && pwm_in) begin
      fn = CAP_FN_PWM;
    end else if (compare_enable_in && mat_in && tog_in) begin
      fn = CAP_FN_HSO;
    end else if (compare_enable_in && mat_in) begin
      fn = CAP_FN_TIMER;
    end else begin
      fn = CAP_FN_IDLE;
    end
  end

  // full equality, only in a counting cycle
  assign match_out = tick_in && compare_enable_in && (count_in == compare_in);

  // ----------------------------------------------------------------------
  // pin and duty next values
  // ----------------------------------------------------------------------
  always_comb begin
    pin_d  = pin_q;
    duty_d = duty_q;
    // reload on low byte wrap keeps the duty glitch free
    if (tick_in && count_in[7:0] == `CAP_DUTY_WRAP) begin
      duty_d = compare_in[15:8];
    end
    case (fn)
      // low below duty, high at or above
      CAP_FN_PWM: begin
        pin_d = (count_in[7:0] >= duty_q);
      end
      // invert on every match
      CAP_FN_HSO: begin
        if (match_out) begin
          pin_d = ~pin_q;
        end
      end
      default: begin
        pin_d = pin_q;   // pin holds its last level
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_q  <= 1'b0;
      duty_q <= `CAP_RST_BYTE;
    end else begin
      pin_q  <= pin_d;
      duty_q <= duty_d;
    end
  end

  assign pin_out = pin_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_toggle_on_match: assert property (
    fn == CAP_FN_HSO && match_out |=> pin_out != $past(pin_out))
    else $error("toggle output did not invert on match");
  a_pwm_level: assert property (
    fn == CAP_FN_PWM |=> pin_out == ($past(count_in[7:0]) >= $past(duty_q)))
    else $error("pwm level does not follow duty comparison");
  a_duty_reload: assert property (
    tick_in && count_in[7:0] == 8'hFF |=> duty_q == $past(compare_in[15:8]))
    else $error("duty byte not reloaded at low byte wrap");
  c_pwm_high: cover property (fn == CAP_FN_PWM ##1 pin_out);
  c_hso_toggle: cover property (fn == CAP_FN_HSO && match_out);

endmodule

// *** logic/cap_pkg.sv ***
/*
  types shared by the counter array compare block.
  assumes: compiled before every module of the block.
*/
package cap_pkg;
  // one register byte
  typedef logic [7:0] cap_byte_t;
  // what a module does with a compare match
  typedef enum {CAP_FN_IDLE, CAP_FN_TIMER, CAP_FN_HSO, CAP_FN_PWM} cap_func_t;
endpackage

// *** logic/cap_regs.svh ***
/*
  register indexes, field positions, reset values and the duty wrap point of
  the counter array compare block.
  assumes: included by bare name after the package; definitions only.
*/
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH

// ----------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define CAP_IDX_CTRL     10'h0_0D8
`define CAP_IDX_WDOG     10'h0_0D9
`define CAP_IDX_MODE0    10'h0_0DA
`define CAP_IDX_CNT_LO   10'h0_0E9
`define CAP_IDX_CMP_LO0  10'h0_0EA
`define CAP_IDX_CNT_HI   10'h0_0F9
`define CAP_IDX_CMP_HI0  10'h0_0FA

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CAP_MODE_IRQ_EN  0
`define CAP_MODE_PWM     1
`define CAP_MODE_TOG     2
`define CAP_MODE_MAT     3
`define CAP_MODE_COMPARE_ENABLE    6
`define CAP_MODE_W       7
`define CAP_CTRL_RUN     6
`define CAP_WDOG_EN      6

// ----------------------------------------------------------------------
// reset values and duty wrap point
// ----------------------------------------------------------------------
`define CAP_RST_BYTE     8'h00
`define CAP_RST_MODE     7'h00
`define CAP_RST_CNT      16'h0000
`define CAP_DUTY_WRAP    8'hFF

`endif

// *** logic/cap_top.sv ***
/*
  counter array compare block: shared 16-bit counter, five compare
  modules with timer, toggle and pwm functions, watchdog on module 4,
  apb register slave.
  assumes: one clock, apb master with synchronous signals, the reset
  request output goes to the device reset controller.
*/
// Functional notes
// - timer mode needs compare and match enables
// - interrupt needs event flag and irq enable
// - writing high compare byte sets compare enable
// - writing low byte clears enabled compare enable
// - toggle mode inverts pin on every match
// - all pwm modules share one counter frequency
// - pwm low below duty, high otherwise
// - duty reloads from high byte at wrap
// - pwm needs pwm bit and compare enable
// - only module four has watchdog function
// - watchdog match issues internal reset request
// - watchdog reset stays internal, no pin
// - clearing watchdog enable prevents the reset
// - match sets sticky flag, software clears it
`timescale 1ns/10ps
`include "cap_regs.svh"
module cap_top
  import cap_pkg::*;
#(
  parameter int NUM_MOD = 5,   // compare modules
  parameter int WDOG_MOD = 4   // module with watchdog function
) (
  input  wire logic                clk_in,           // 25 MHz system clock
  input  wire logic                sys_rst_in,       // synchronous reset
  input  wire logic                psel_in,          // apb select
  input  wire logic                penable_in,       // apb enable
  input  wire logic                pwrite_in,        // apb direction
  input  wire logic [11:0]         paddr_in,         // apb byte address
  input  wire logic [31:0]         pwdata_in,        // apb write data
  output logic      [31:0]         prdata_out,       // apb read data
  output logic                     pready_out,       // apb ready
  output logic                     pslverr_out,      // apb error
  output logic      [NUM_MOD-1:0]  module_io_pin_out, // module pins
  output logic                     irq_out,          // interrupt request
  output logic                     wdog_reset_out    // internal reset request
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [`CAP_MODE_W-1:0] mode_q [NUM_MOD];   // module_mode_reg
  logic [`CAP_MODE_W-1:0] mode_d [NUM_MOD];
  cap_byte_t              lo_q   [NUM_MOD];   // compare_value_low
  cap_byte_t              lo_d   [NUM_MOD];
  cap_byte_t              hi_q   [NUM_MOD];   // compare_value_high
  cap_byte_t              hi_d   [NUM_MOD];
  logic [NUM_MOD-1:0]     flag_q;             // module_event_flag
  logic [NUM_MOD-1:0]     flag_d;
  logic [15:0]            cnt_q;              // shared counter
  logic [15:0]            cnt_d;
  logic                   run_q;              // counter runs
  logic                   run_d;
  logic                   wdog_en_q;          // watchdog_enable
  logic                   wdog_en_d;
  logic                   wdog_rst_q;         // reset request pulse
  logic                   wdog_rst_d;
  logic [31:0]            rdata_q;            // read data, loaded in setup
  logic [31:0]            rdata_d;
  logic [NUM_MOD-1:0]     match;              // per-module match pulses
  logic [NUM_MOD-1:0]     pin;                // per-module pin levels

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic       setup;      // setup phase
  logic       access;     // access phase
  logic       wr;         // write takes effect this edge
  logic [9:0] idx;        // register index
  logic       hit;        // address maps to a register

  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wr     = access && pwrite_in;
  assign idx    = paddr_in[11:2];

  // module-indexed windows are checked by range
  function automatic logic in_win(input logic [9:0] a, input logic [9:0] base);
    in_win = (a >= base) && (a < base + 10'(NUM_MOD));
  endfunction

  always_comb begin
    hit = in_win(idx, `CAP_IDX_MODE0) || in_win(idx, `CAP_IDX_CMP_LO0) ||
          in_win(idx, `CAP_IDX_CMP_HI0) || idx == `CAP_IDX_CTRL ||
          idx == `CAP_IDX_WDOG || idx == `CAP_IDX_CNT_LO ||
          idx == `CAP_IDX_CNT_HI;
  end

  // zero-wait slave; an unmapped address answers with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !hit;

  // ----------------------------------------------------------------------
  // compare modules
  // ----------------------------------------------------------------------
  // one counter feeds every module, so pwm frequency is common
  for (genvar n = 0; n < NUM_MOD; n++) begin : g_mod
    cap_cmp_unit u_unit (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .tick_in    (run_q),
      .count_in   (cnt_q),
      .compare_in ({hi_q[n], lo_q[n]}),
      .compare_enable_in    (mode_q[n][`CAP_MODE_COMPARE_ENABLE]),
      .mat_in     (mode_q[n][`CAP_MODE_MAT]),
      .tog_in     (mode_q[n][`CAP_MODE_TOG]),
      .pwm_in     (mode_q[n][`CAP_MODE_PWM]),
      .match_out  (match[n]),
      .pin_out    (pin[n])
    );
  end

  // ----------------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------------
  always_comb begin
    run_d     = run_q;
    wdog_en_d = wdog_en_q;
    flag_d    = flag_q;
    // counter steps every cycle while running
    cnt_d     = run_q ? cnt_q + 16'h0001 : cnt_q;
    for (int n = 0; n < NUM_MOD; n++) begin
      mode_d[n] = mode_q[n];
      lo_d[n]   = lo_q[n];
      hi_d[n]   = hi_q[n];
      if (wr && idx == `CAP_IDX_MODE0 + 10'(n)) begin
        // compare enable stays writable here as well
        mode_d[n] = pwdata_in[`CAP_MODE_W-1:0];
      end
      if (wr && idx == `CAP_IDX_CMP_LO0 + 10'(n)) begin
        lo_d[n] = pwdata_in[7:0];
        // stop matches while the value is half written
        if (mode_q[n][`CAP_MODE_COMPARE_ENABLE]) begin
          mode_d[n][`CAP_MODE_COMPARE_ENABLE] = 1'b0;
        end
      end
      if (wr && idx == `CAP_IDX_CMP_HI0 + 10'(n)) begin
        hi_d[n] = pwdata_in[7:0];
        mode_d[n][`CAP_MODE_COMPARE_ENABLE] = 1'b1;
      end
    end
    if (wr && idx == `CAP_IDX_CTRL) begin
      run_d  = pwdata_in[`CAP_CTRL_RUN];
      flag_d = pwdata_in[NUM_MOD-1:0];      // software clears flags
    end
    if (wr && idx == `CAP_IDX_WDOG) begin
      wdog_en_d = pwdata_in[`CAP_WDOG_EN];  // clear to hold off
    end
    if (wr && idx == `CAP_IDX_CNT_LO) begin
      cnt_d[7:0] = pwdata_in[7:0];
    end
    if (wr && idx == `CAP_IDX_CNT_HI) begin
      cnt_d[15:8] = pwdata_in[7:0];
    end
    // match sets the flag and wins over a clear
    for (int n = 0; n < NUM_MOD; n++) begin
      if (match[n] && mode_q[n][`CAP_MODE_MAT]) begin
        flag_d[n] = 1'b1;
      end
    end
    // only the watchdog module may request a reset
    wdog_rst_d = wdog_en_q && match[WDOG_MOD];
  end

  // ----------------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      for (int n = 0; n < NUM_MOD; n++) begin
        if (idx == `CAP_IDX_MODE0 + 10'(n)) begin
          rdata_d[`CAP_MODE_W-1:0] = mode_q[n];
        end
        if (idx == `CAP_IDX_CMP_LO0 + 10'(n)) begin
          rdata_d[7:0] = lo_q[n];
        end
        if (idx == `CAP_IDX_CMP_HI0 + 10'(n)) begin
          rdata_d[7:0] = hi_q[n];
        end
      end
      if (idx == `CAP_IDX_CTRL) begin
        rdata_d[NUM_MOD-1:0]    = flag_q;
        rdata_d[`CAP_CTRL_RUN]  = run_q;
      end
      if (idx == `CAP_IDX_WDOG) begin
        rdata_d[`CAP_WDOG_EN] = wdog_en_q;
      end
      if (idx == `CAP_IDX_CNT_LO) begin
        rdata_d[7:0] = cnt_q[7:0];
      end
      if (idx == `CAP_IDX_CNT_HI) begin
        rdata_d[7:0] = cnt_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int n = 0; n < NUM_MOD; n++) begin
        mode_q[n] <= `CAP_RST_MODE;
        lo_q[n]   <= `CAP_RST_BYTE;
        hi_q[n]   <= `CAP_RST_BYTE;
      end
      flag_q     <= '0;
      cnt_q      <= `CAP_RST_CNT;
      run_q      <= 1'b0;
      wdog_en_q  <= 1'b0;
      wdog_rst_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      mode_q     <= mode_d;
      lo_q       <= lo_d;
      hi_q       <= hi_d;
      flag_q     <= flag_d;
      cnt_q      <= cnt_d;
      run_q      <= run_d;
      wdog_en_q  <= wdog_en_d;
      wdog_rst_q <= wdog_rst_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic [NUM_MOD-1:0] irq_en;   // module_irq_enable bits
  always_comb begin
    for (int n = 0; n < NUM_MOD; n++) begin
      irq_en[n] = mode_q[n][`CAP_MODE_IRQ_EN];
    end
  end

  // flag and enable both needed
  assign irq_out           = |(flag_q & irq_en);
  // internal request only; no reset pin is driven
  assign wdog_reset_out    = wdog_rst_q;
  assign module_io_pin_out = pin;
  assign prdata_out        = rdata_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_hi_sets_compare_enable: assert property (
    wr && idx == `CAP_IDX_CMP_HI0 |=> mode_q[0][`CAP_MODE_COMPARE_ENABLE])
    else $error("high byte write did not set compare enable");
  a_lo_clears_compare_enable: assert property (
    wr && idx == `CAP_IDX_CMP_LO0 |=> !mode_q[0][`CAP_MODE_COMPARE_ENABLE])
    else $error("low byte write left compare enable set");
  a_flag_on_match: assert property (
    match[1] && mode_q[1][`CAP_MODE_MAT] |=> flag_q[1])
    else $error("match did not set event flag");
  a_flag_sticky: assert property (
    flag_q[2] && !(wr && idx == `CAP_IDX_CTRL) |=> flag_q[2])
    else $error("event flag cleared without software write");
  a_irq_gating: assert property (
    (flag_q[1] && mode_q[1][`CAP_MODE_IRQ_EN] |-> irq_out) and
    (flag_q == '0 |-> !irq_out))
    else $error("interrupt does not follow flag and enable");
  a_timer_match: assert property (
    run_q && mode_q[3][`CAP_MODE_COMPARE_ENABLE] && cnt_q == {hi_q[3], lo_q[3]} |-> match[3])
    else $error("16-bit equality gave no match");
  a_wdog_fires: assert property (
    wdog_en_q && match[WDOG_MOD] |=> wdog_reset_out ##1 !wdog_reset_out)
    else $error("watchdog match gave no single reset pulse");
  a_wdog_held: assert property (
    !wdog_en_q |=> !wdog_reset_out)
    else $error("reset request while watchdog disabled");
  a_count_step: assert property (
    run_q && !wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step");

  c_wdog_reset: cover property (wdog_reset_out);
  c_irq: cover property (irq_out);
  c_flag_clear: cover property (flag_q[0] ##1 !flag_q[0]);

endmodule
